//--- amm_pkg.sv
// Constants shared by the alarm mask and mute logic.
package amm_pkg;

    // ------------------------------------------------------------
    // Register indices and bus geometry
    // ------------------------------------------------------------
    localparam int unsigned REG_W = 8;
    localparam int unsigned NUM_BANKS = 4;
    localparam int unsigned ADDR_W = 14;
    localparam int unsigned IDX_W = 12;
    localparam logic [IDX_W-1:0] FIFO_FLAGS_IDX = 12'h820;
    localparam logic [IDX_W-1:0] LINK_FLAGS_IDX = 12'h821;
    localparam logic [IDX_W-1:0] SYS_FLAGS_IDX = 12'h822;
    localparam logic [IDX_W-1:0] ALARM_MASK_IDX = 12'h823;
    localparam logic [IDX_W-1:0] MUTE_MASK_IDX = 12'h824;
    localparam logic [IDX_W-1:0] BANK_CFG_IDX = 12'h825;
    localparam logic [IDX_W-1:0] ALIGN_CTRL_IDX = 12'h826;
    localparam logic [IDX_W-1:0] OUT_STATE_IDX = 12'h827;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned TRIG_BIT = 2;
    localparam int unsigned PHASE_BIT = 1;
    localparam int unsigned CLKS_BIT = 0;
    localparam int unsigned SYS_FLAG_W = 3;
    localparam int unsigned SYS_SPARE_LSB = 3;
    localparam int unsigned FIFO_GRP_BIT = 7;
    localparam int unsigned LINK_GRP_BIT = 6;
    localparam int unsigned STROBE_GRP_BIT = 5;
    localparam int unsigned ALIGN_EN_BIT = 0;
    localparam int unsigned ALARM_STATE_BIT = 0;
    localparam int unsigned MUTE_STATE_BIT = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [REG_W-1:0] SYS_FLAGS_RST = 8'h00;
    localparam logic [REG_W-1:0] ALARM_MASK_RST = 8'h00;
    localparam logic [REG_W-1:0] MUTE_MASK_RST = 8'h07;
    localparam logic [REG_W-1:0] BANK_CFG_RST = 8'h00;
    localparam logic [REG_W-1:0] ALIGN_CTRL_RST = 8'h00;

endpackage

//--- amm_sticky_flags.sv
// Bank of sticky event flags with write-one-to-clear.
module amm_sticky_flags #(
    parameter int unsigned W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] set_event,
    input wire logic [W-1:0] clear_ones,
    output logic [W-1:0] flags
);

    // ------------------------------------------------------------
    // Per-bit flag storage
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_flag
            logic next_flag;
            assign next_flag = set_event[i] | (flags[i] & ~clear_ones[i]);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flags[i] <= 1'b0;
                end else begin
                    flags[i] <= next_flag;
                end
            end
        end
    endgenerate

endmodule // amm_sticky_flags

//--- amm_group_route.sv
// Combines alarm groups under one mask into a single request.
module amm_group_route (
    input wire logic [7:0] fifo_flags,
    input wire logic [7:0] link_flags,
    input wire logic [2:0] sys_flags,
    input wire logic [7:0] block_mask,
    output logic active
);

    // ------------------------------------------------------------
    // Group reduction
    // ------------------------------------------------------------
    function automatic logic group_on(input logic [7:0] v, input logic blk);
        group_on = (|v) & ~blk;
    endfunction

    logic fifo_on;
    logic clk_loss_on;
    logic strobe_on;
    logic [2:0] sys_on;

    assign fifo_on = group_on(fifo_flags, block_mask[amm_pkg::FIFO_GRP_BIT]);
    assign clk_loss_on = group_on({4'h0, link_flags[7:4]}, block_mask[amm_pkg::LINK_GRP_BIT]);
    assign strobe_on = group_on({4'h0, link_flags[3:0]}, block_mask[amm_pkg::STROBE_GRP_BIT]);
    assign sys_on = sys_flags & ~block_mask[2:0];
    assign active = fifo_on | clk_loss_on | strobe_on | (|sys_on);

endmodule // amm_group_route

//--- amm_alarm_mute.sv
// Alarm flag collection, alarm output and mute request with APB registers.
//
// The implementer's own choice: the APB slave port.
module amm_alarm_mute (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] fifo_almost_full,
    input wire logic [3:0] fifo_almost_empty,
    input wire logic [3:0] link_clock_stopped,
    input wire logic [3:0] strobe_misplaced,
    input wire logic trigger_divider_realigned,
    input wire logic reference_edge_seen,
    input wire logic reference_edge_misplaced,
    input wire logic clocks_realigned_event,
    output logic reference_align_enable,
    output logic alarm_out,
    output logic mute_request
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic reg_hit(input logic [13:0] a, input logic [11:0] idx);
        reg_hit = (a[13:2] == idx) && (a[1:0] == 2'h0);
    endfunction

    logic hit_fifo;
    logic hit_link;
    logic hit_sys;
    logic hit_amask;
    logic hit_mmask;
    logic hit_bank;
    logic hit_align;
    logic hit_state;
    logic mapped;
    logic access;
    logic setup_rd;
    logic wr_en;

    assign hit_fifo = reg_hit(paddr, amm_pkg::FIFO_FLAGS_IDX);
    assign hit_link = reg_hit(paddr, amm_pkg::LINK_FLAGS_IDX);
    assign hit_sys = reg_hit(paddr, amm_pkg::SYS_FLAGS_IDX);
    assign hit_amask = reg_hit(paddr, amm_pkg::ALARM_MASK_IDX);
    assign hit_mmask = reg_hit(paddr, amm_pkg::MUTE_MASK_IDX);
    assign hit_bank = reg_hit(paddr, amm_pkg::BANK_CFG_IDX);
    assign hit_align = reg_hit(paddr, amm_pkg::ALIGN_CTRL_IDX);
    assign hit_state = reg_hit(paddr, amm_pkg::OUT_STATE_IDX);
    assign mapped = hit_fifo | hit_link | hit_sys | hit_amask | hit_mmask | hit_bank | hit_align | hit_state;
    assign access = psel & penable;
    assign setup_rd = psel & ~penable & ~pwrite;
    assign wr_en = access & pwrite & pstrb[0] & mapped;
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // ------------------------------------------------------------
    // Write strobes
    // ------------------------------------------------------------
    logic wr_fifo;
    logic wr_link;
    logic wr_sys;
    logic [7:0] wbyte;

    assign wr_fifo = wr_en & hit_fifo;
    assign wr_link = wr_en & hit_link;
    assign wr_sys = wr_en & hit_sys;
    assign wbyte = pwdata[7:0];

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [7:0] alarm_output_mask;
    logic [7:0] output_mute_mask;
    logic [7:0] bank_config;
    logic [7:0] align_control;
    logic [4:0] sys_spare;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_output_mask <= amm_pkg::ALARM_MASK_RST;
            output_mute_mask <= amm_pkg::MUTE_MASK_RST;
            bank_config <= amm_pkg::BANK_CFG_RST;
            align_control <= amm_pkg::ALIGN_CTRL_RST;
            sys_spare <= amm_pkg::SYS_FLAGS_RST[7:3];
        end else begin
            if (wr_en & hit_amask) begin
                alarm_output_mask <= wbyte;
            end
            if (wr_en & hit_mmask) begin
                output_mute_mask <= wbyte;
            end
            if (wr_en & hit_bank) begin
                bank_config <= wbyte;
            end
            if (wr_en & hit_align) begin
                align_control <= wbyte;
            end
            if (wr_sys) begin
                sys_spare <= wbyte[7:3];
            end
        end
    end

    assign reference_align_enable = align_control[amm_pkg::ALIGN_EN_BIT];

    // ------------------------------------------------------------
    // Flag sources
    // ------------------------------------------------------------
    logic [7:0] fifo_set;
    logic [7:0] link_set;
    logic [2:0] sys_set;
    logic [7:0] fifo_level_flags;
    logic [7:0] link_flags;
    logic [2:0] system_event_flags;
    logic [3:0] link_clock_loss_flags;
    logic [3:0] strobe_position_flags;

    assign fifo_set = {fifo_almost_empty & bank_config[3:0], fifo_almost_full & bank_config[3:0]};
    assign link_set[7:4] = link_clock_stopped & bank_config[7:4];
    assign link_set[3:0] = strobe_misplaced;
    assign sys_set[amm_pkg::TRIG_BIT] = trigger_divider_realigned;
    assign sys_set[amm_pkg::PHASE_BIT] = reference_edge_seen & reference_edge_misplaced & ~reference_align_enable;
    assign sys_set[amm_pkg::CLKS_BIT] = clocks_realigned_event;

    amm_sticky_flags #(
        .W(8)
    ) u_fifo_flags (
        .pclk(pclk),
        .presetn(presetn),
        .set_event(fifo_set),
        .clear_ones(wr_fifo ? wbyte : 8'h00),
        .flags(fifo_level_flags)
    );

    amm_sticky_flags #(
        .W(8)
    ) u_link_flags (
        .pclk(pclk),
        .presetn(presetn),
        .set_event(link_set),
        .clear_ones(wr_link ? wbyte : 8'h00),
        .flags(link_flags)
    );

    amm_sticky_flags #(
        .W(3)
    ) u_sys_flags (
        .pclk(pclk),
        .presetn(presetn),
        .set_event(sys_set),
        .clear_ones(wr_sys ? wbyte[2:0] : 3'h0),
        .flags(system_event_flags)
    );

    assign link_clock_loss_flags = link_flags[7:4];
    assign strobe_position_flags = link_flags[3:0];

    // ------------------------------------------------------------
    // Alarm and mute routing
    // ------------------------------------------------------------
    logic next_alarm;
    logic next_mute;

    amm_group_route u_alarm_route (
        .fifo_flags(fifo_level_flags),
        .link_flags(link_flags),
        .sys_flags(system_event_flags),
        .block_mask(alarm_output_mask),
        .active(next_alarm)
    );

    amm_group_route u_mute_route (
        .fifo_flags(fifo_level_flags),
        .link_flags(link_flags),
        .sys_flags(system_event_flags),
        .block_mask(output_mute_mask),
        .active(next_mute)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_out <= 1'b0;
            mute_request <= 1'b0;
        end else begin
            alarm_out <= next_alarm;
            mute_request <= next_mute;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [7:0] rd_byte;

    assign rd_byte = hit_fifo ? fifo_level_flags :
                     hit_link ? link_flags :
                     hit_sys ? {sys_spare, system_event_flags} :
                     hit_amask ? alarm_output_mask :
                     hit_mmask ? output_mute_mask :
                     hit_bank ? bank_config :
                     hit_align ? align_control :
                     hit_state ? {6'h00, mute_request, alarm_out} : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_rd) begin
            prdata <= {24'h000000, rd_byte};
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_trig_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        trigger_divider_realigned |=> system_event_flags[2] ##1 (alarm_out || alarm_output_mask[2]))
        else $error("Trigger realign flag or alarm missing.");

    a_phase_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        reference_edge_seen && reference_edge_misplaced && !reference_align_enable |=> system_event_flags[1])
        else $error("Phase error flag not set.");

    a_phase_flag_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !system_event_flags[1] && reference_align_enable && !wr_en |=> !system_event_flags[1])
        else $error("Phase error flag set while alignment enabled.");

    a_clks_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        clocks_realigned_event |=> system_event_flags[0])
        else $error("Clocks realigned flag not set.");

    a_w1c_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn)
        system_event_flags[0] && !(wr_sys && pwdata[0]) |=> system_event_flags[0])
        else $error("System flag lost without a written one.");

    a_w1c_one_clears: assert property (@(posedge pclk) disable iff (!presetn)
        wr_sys && pwdata[0] && !clocks_realigned_event |=> !system_event_flags[0])
        else $error("System flag not cleared by written one.");

    a_fifo_alarm_mask: assert property (@(posedge pclk) disable iff (!presetn)
        (|fifo_level_flags) && !alarm_output_mask[7] |=> alarm_out)
        else $error("FIFO alarm did not reach alarm output.");

    a_link_alarm_mask: assert property (@(posedge pclk) disable iff (!presetn)
        (|link_clock_loss_flags) && !alarm_output_mask[6] |=> alarm_out)
        else $error("Clock-loss alarm did not reach alarm output.");

    a_strobe_alarm_mask: assert property (@(posedge pclk) disable iff (!presetn)
        (|strobe_position_flags) && !alarm_output_mask[5] |=> alarm_out)
        else $error("Strobe alarm did not reach alarm output.");

    a_sys_alarm_block: assert property (@(posedge pclk) disable iff (!presetn)
        fifo_level_flags == 8'h00 && link_flags == 8'h00 && (system_event_flags & ~alarm_output_mask[2:0]) == 3'h0
        |=> !alarm_out)
        else $error("Blocked alarm reached alarm output.");

    a_fifo_mute: assert property (@(posedge pclk) disable iff (!presetn)
        (|fifo_level_flags) && !output_mute_mask[7] |=> mute_request)
        else $error("FIFO alarm did not mute.");

    a_link_mute: assert property (@(posedge pclk) disable iff (!presetn)
        (|link_clock_loss_flags) && !output_mute_mask[6] |=> mute_request)
        else $error("Clock-loss alarm did not mute.");

    a_strobe_mute: assert property (@(posedge pclk) disable iff (!presetn)
        (|strobe_position_flags) && !output_mute_mask[5] |=> mute_request)
        else $error("Strobe alarm did not mute.");

    a_sys_mute_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (system_event_flags & ~output_mute_mask[2:0]) != 3'h0 |=> mute_request)
        else $error("System flag did not mute.");

    a_mute_mask_reset: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> output_mute_mask == 8'h07)
        else $error("Mute mask reset value wrong.");

    a_fifo_bank_flag: assert property (@(posedge pclk) disable iff (!presetn)
        fifo_almost_full[0] && bank_config[0] |=> fifo_level_flags[0])
        else $error("Enabled bank FIFO flag not raised.");

    a_clock_loss_flag: assert property (@(posedge pclk) disable iff (!presetn)
        link_clock_stopped[1] && bank_config[5] |=> link_clock_loss_flags[1])
        else $error("Used bank clock-loss flag not raised.");

    a_strobe_flag: assert property (@(posedge pclk) disable iff (!presetn)
        strobe_misplaced[2] |=> strobe_position_flags[2])
        else $error("Strobe flag not raised.");

    a_spare_readback: assert property (@(posedge pclk) disable iff (!presetn)
        wr_sys |=> sys_spare == $past(pwdata[7:3]))
        else $error("Reserved bits did not store write.");

endmodule // amm_alarm_mute

//--- tb_alarm_mask_and_mute_logic.sv
// Self-checking testbench for the alarm mask and mute logic.
module tb_alarm_mask_and_mute_logic;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals and reference model state
    // ------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic tr, rs, rm, cr, align_en, alarm_out, mute_request;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rd, r;
    logic [3:0] pstrb, ff, fe, lc, sm;
    int error_cnt, comparisons, cycles, seed;
    int m_fifo, m_link, m_sys, m_am, m_mm, m_cfg, m_al;
    int expq[$];
    int mbit[6] = '{7, 6, 5, 2, 1, 0};
    int fidx[6] = '{0, 1, 1, 2, 2, 2};
    logic [19:0] src[6] = '{20'h20000, 20'h00400, 20'h00080, 20'h00008, 20'h00006, 20'h00001};

    amm_alarm_mute DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fifo_almost_full(ff), .fifo_almost_empty(fe), .link_clock_stopped(lc), .strobe_misplaced(sm),
        .trigger_divider_realigned(tr), .reference_edge_seen(rs), .reference_edge_misplaced(rm),
        .clocks_realigned_event(cr), .reference_align_enable(align_en), .alarm_out(alarm_out),
        .mute_request(mute_request));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Model, bus and compare tasks
    // ------------------------------------------------------------
    // OR of unmasked groups.
    function automatic logic grp(input int msk);
        grp = ((m_fifo != 0) && !msk[7]) || ((m_link[7:4] != 0) && !msk[6])
            || ((m_link[3:0] != 0) && !msk[5]) || ((m_sys & ~msk & 7) != 0);
    endfunction

    function automatic int exp_reg(input int i);
        int v[8];
        v = '{m_fifo, m_link, m_sys, m_am, m_mm, m_cfg, m_al, 2 * grp(m_mm) + grp(m_am)};
        exp_reg = v[i];
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [13:0] a, input logic [7:0] d, input logic [3:0] st);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input int i, input logic [7:0] d, input logic [3:0] st);
        apb(1'b1, 14'h2080 + 14'(i * 4), d, st);
        if (st[0]) begin
            case (i)
                0: m_fifo &= ~int'(d);
                1: m_link &= ~int'(d);
                2: m_sys = (d & 8'hF8) | (m_sys & ~int'(d) & 7);
                3: m_am = d;
                4: m_mm = d;
                5: m_cfg = d;
                6: m_al = d;
                default: ;
            endcase
        end
    endtask

    task automatic fire(input logic [19:0] v);
        @(posedge pclk);
        {ff, fe, lc, sm, tr, rs, rm, cr} <= v;
        @(posedge pclk);
        {ff, fe, lc, sm, tr, rs, rm, cr} <= 20'h00000;
        m_fifo |= (int'(v[15:12] & m_cfg[3:0]) << 4) | int'(v[19:16] & m_cfg[3:0]);
        m_link |= (int'(v[11:8] & m_cfg[7:4]) << 4) | int'(v[7:4]);
        m_sys |= int'({v[3], v[2] & v[1] & !m_al[0], v[0]});
    endtask

    task automatic check_all();
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk_pin(alarm_out, grp(m_am), "alarm");
        chk_pin(mute_request, grp(m_mm), "mute");
        chk_pin(align_en, m_al[0], "align enable");
        for (int i = 0; i < 8; i++) begin
            expq.push_back(exp_reg(i));
        end
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 14'h2080 + 14'(i * 4), 8'h00, 4'hF);
            chk(rd, expq.pop_front(), "register");
            chk_pin(err, 1'b0, "error flag");
        end
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        m_fifo = 0;
        m_link = 0;
        m_sys = 0;
        m_am = 0;
        m_mm = 7;
        m_cfg = 0;
        m_al = 0;
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            error_cnt++;
            $display("wrong value at %0t: run timed out", $time);
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        seed = 55387;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {ff, fe, lc, sm, tr, rs, rm, cr} = '0;
        presetn = 1'b0;
        do_reset();
        check_all();
        $display("test reset values done");
        // each event is a lone pulse.
        for (int g = 0; g < 6; g++) begin
            wr(5, 8'hFF, 4'hF);
            wr(4, 8'h00, 4'hF);
            fire(src[g]);
            check_all();
            wr(3, 8'(1 << mbit[g]), 4'hF);
            check_all();
            wr(4, 8'(1 << mbit[g]), 4'hF);
            check_all();
            wr(fidx[g], 8'h00, 4'hF);
            wr(3, 8'h00, 4'hF);
            check_all();
            wr(fidx[g], 8'hFF, 4'hF);
            check_all();
        end
        $display("test group routing done");
        apb(1'b0, 14'h20A0, 8'h00, 4'hF);
        chk(rd, 32'h00000000, "unmapped data");
        chk_pin(err, 1'b1, "unmapped error");
        apb(1'b1, 14'h208E, 8'h55, 4'hF);
        chk_pin(err, 1'b1, "misaligned error");
        wr(3, 8'hAA, 4'h0);
        wr(7, 8'hFF, 4'hF);
        check_all();
        $display("test refused accesses done");
        for (int n = 0; n < 120; n++) begin
            r = $random(seed);
            if (r[0])
                fire(r[31:12]);
            else
                wr(int'(r[3:1]), (r[3:1] == 3'h6) ? {7'h00, r[8]} : r[15:8], (r[5] & r[6]) ? 4'hE : 4'hF);
            check_all();
        end
        $display("test random traffic done");
        do_reset();
        check_all();
        $display("test second reset done");
        summarize();
    end
endmodule // tb_alarm_mask_and_mute_logic
